// file: common/ptmr_cnt_if.sv
// ptmr_cnt_if: control and status between the timer core and its counter.
// assumes one clock domain; the core drives controls, the counter answers.
interface ptmr_cnt_if #(parameter int W = 10);
  logic clear;
  logic en;
  logic p_clr_en;
  logic a_clr_en;
  logic [W-1:0] cmp_a;
  logic [W-1:0] cmp_p;
  logic [W-1:0] count;
  logic a_hit;
  logic p_hit;
  modport ctrl (output clear, en, p_clr_en, a_clr_en, cmp_a, cmp_p, input count, a_hit, p_hit);
  modport cnt (input clear, en, p_clr_en, a_clr_en, cmp_a, cmp_p, output count, a_hit, p_hit);
endinterface : ptmr_cnt_if

// file: common/ptmr_pkg.sv
// ptmr_pkg: shared constants and types of the periodic timer pulse/capture block.
// assumes a 16-bit register port with word indices 0..5 and a 10-bit counter.
package ptmr_pkg;
  // widths
  localparam int PTMR_CNT_W = 10;
  localparam int PTMR_REG_W = 16;
  localparam int PTMR_ADDR_W = 3;

  // register indices on the plain register port
  localparam logic [2:0] PTMR_OFF_TIMER_CONTROL_ZERO = 3'h0;
  localparam logic [2:0] PTMR_OFF_TIMER_CONTROL_ONE = 3'h1;
  localparam logic [2:0] PTMR_OFF_COUNT = 3'h2;
  localparam logic [2:0] PTMR_OFF_COMPARE_A = 3'h3;
  localparam logic [2:0] PTMR_OFF_PERIOD_COMPARE = 3'h4;
  localparam logic [2:0] PTMR_OFF_FLAGS = 3'h5;

  // timer_control_zero fields
  localparam int PTMR_C0_RUN = 0;
  localparam int PTMR_C0_CAPSRC = 1;
  localparam int PTMR_C0_PINSEL = 2;
  // timer_control_one fields
  localparam int PTMR_C1_CCLR = 0;
  localparam int PTMR_C1_POL = 2;
  localparam int PTMR_C1_INIT = 3;
  localparam int PTMR_C1_FN_LO = 4;
  localparam int PTMR_C1_FN_HI = 5;
  localparam int PTMR_C1_MODE_LO = 6;
  localparam int PTMR_C1_MODE_HI = 7;
  // flag register fields, write one to clear
  localparam int PTMR_FL_A = 0;
  localparam int PTMR_FL_P = 1;

  // reset values
  localparam logic PTMR_RST_BIT = 1'b0;
  localparam logic [1:0] PTMR_RST_FN = 2'h0;
  localparam logic [9:0] PTMR_RST_CMP = 10'h000;
  localparam logic [15:0] PTMR_RST_RDATA = 16'h0000;

  // operating modes
  typedef enum logic [1:0] {
    PTMR_MODE_CMP = 2'b00,
    PTMR_MODE_CAP = 2'b01,
    PTMR_MODE_WAVE = 2'b10,
    PTMR_MODE_TIMER = 2'b11
  } ptmr_mode_e;

  // pin function codes, capture meaning and waveform meaning
  localparam logic [1:0] PTMR_FN_RISE = 2'b00;
  localparam logic [1:0] PTMR_FN_FALL = 2'b01;
  localparam logic [1:0] PTMR_FN_BOTH = 2'b10;
  localparam logic [1:0] PTMR_FN_FORCE_LO = 2'b00;
  localparam logic [1:0] PTMR_FN_FORCE_HI = 2'b01;
  localparam logic [1:0] PTMR_FN_PULSE = 2'b11;

  // edge detector lanes
  localparam int PTMR_SRC_FIRST = 0;
  localparam int PTMR_SRC_SECOND = 1;
  localparam int PTMR_SRC_EXT = 2;
endpackage : ptmr_pkg

// file: hw/ptmr_counter.sv
// ptmr_counter: up counter with start clear and comparator A/P matches.
// assumes the core holds en low when stopped; clear outranks counting.
module ptmr_counter #(
  parameter int W = 10
) (
  input wire logic core_clk, // timer clock
  input wire logic rst,      // async reset, high
  input wire logic ce,       // clock enable
  ptmr_cnt_if.cnt bus        // controls and matches
);
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = '0;
  logic [W-1:0] inc;

  // a match means the next count reaches the compare value
  assign inc = bus.count + ONE;
  assign bus.a_hit = bus.en && (inc == bus.cmp_a);
  assign bus.p_hit = bus.en && bus.p_clr_en && (inc == bus.cmp_p);

  // counting, stop holds the value for software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus.count <= ZERO;
    end else if (ce) begin
      if (bus.clear) begin
        bus.count <= ZERO;
      end else if (bus.p_hit || (bus.a_hit && bus.a_clr_en)) begin
        bus.count <= ZERO;
      end else if (bus.en) begin
        bus.count <= inc;
      end
    end
  end
endmodule : ptmr_counter

// file: hw/ptmr_edge.sv
// ptmr_edge: rising and falling edge pulses for a group of pin samples.
// assumes inputs already synchronous to core_clk; pulses are combinational, in the cycle of the new sample.
module ptmr_edge #(
  parameter int W = 3
) (
  input wire logic core_clk,      // timer clock
  input wire logic rst,           // async reset, high
  input wire logic ce,            // clock enable
  input wire logic [W-1:0] din,   // pin samples
  output logic [W-1:0] rise,      // rising edge pulse
  output logic [W-1:0] fall       // falling edge pulse
);
  logic [W-1:0] prev_reg;

  // previous sample; frozen with ce so no edge is invented
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '0;
    end else if (ce) begin
      prev_reg <= din;
    end
  end

  assign rise = din & ~prev_reg;
  assign fall = ~din & prev_reg;
endmodule : ptmr_edge

// file: hw/ptmr_top.sv
// ptmr_top: periodic timer with single pulse, capture, pwm and compare output.
// assumes pins synchronous to core_clk and a register master that never waits.
module ptmr_top
  import ptmr_pkg::*;
#(
  parameter int CNT_W = PTMR_CNT_W
) (
  input wire logic core_clk,                  // timer clock, 100 MHz
  input wire logic rst,                       // async reset, high
  input wire logic ce,                        // clock enable, freezes all
  input wire logic [PTMR_ADDR_W-1:0] reg_addr, // register index
  input wire logic [PTMR_REG_W-1:0] reg_wdata, // write data
  input wire logic reg_we,                    // write strobe
  input wire logic reg_re,                    // read strobe
  output logic [PTMR_REG_W-1:0] reg_rdata,    // read data, cycle after strobe
  input wire logic external_timer_clock_pin,  // external trigger pin
  input wire logic timer_io_pin_first_in,     // first io pin level
  output logic timer_io_pin_first_out,        // first io pin drive value
  output logic timer_io_pin_first_oe_n,       // first io pin enable, low drives
  input wire logic timer_io_pin_second_in,    // second io pin level
  output logic timer_io_pin_second_out,       // second io pin drive value
  output logic timer_io_pin_second_oe_n,      // second io pin enable, low drives
  output logic a_match_flag,                  // A request flag
  output logic p_match_flag                   // P request flag
);
  // control state
  logic run_reg;
  logic run_next;
  logic cap_src_reg;
  logic pin_sel_reg;
  ptmr_mode_e mode_reg;
  logic [1:0] pin_fn_reg;
  logic init_lvl_reg;
  logic pol_reg;
  logic cclr_reg;
  logic [CNT_W-1:0] cmp_a_reg;
  logic [CNT_W-1:0] cmp_p_reg;
  logic flag_a_reg;
  logic flag_p_reg;
  logic cmp_lvl_reg;
  logic pin_out_reg;
  logic pin_oe_n_reg;
  logic [PTMR_REG_W-1:0] rdata_reg;

  // decoded strobes and mode terms
  logic wr_c0;
  logic wr_c1;
  logic wr_a;
  logic wr_p;
  logic wr_fl;
  logic sp_mode;
  logic pwm_mode;
  logic cap_mode;
  logic cmp_mode;
  logic start;
  logic [2:0] pins;
  logic [2:0] rise_v;
  logic [2:0] fall_v;
  logic cap_rise;
  logic cap_fall;
  logic cap_edge;
  logic cap_evt;
  logic ext_trig;
  logic set_a;
  logic lvl;

  ptmr_cnt_if #(.W(CNT_W)) cnt ();

  // register write decode, shared by every write port
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off, input logic stb);
    return stb && (a == off);
  endfunction : hit

  assign wr_c0 = ce && hit(reg_addr, PTMR_OFF_TIMER_CONTROL_ZERO, reg_we);
  assign wr_c1 = ce && hit(reg_addr, PTMR_OFF_TIMER_CONTROL_ONE, reg_we);
  assign wr_a = ce && hit(reg_addr, PTMR_OFF_COMPARE_A, reg_we);
  assign wr_p = ce && hit(reg_addr, PTMR_OFF_PERIOD_COMPARE, reg_we);
  assign wr_fl = ce && hit(reg_addr, PTMR_OFF_FLAGS, reg_we);

  // mode decode
  // pulse mode select
  assign sp_mode = (mode_reg == PTMR_MODE_WAVE) && (pin_fn_reg == PTMR_FN_PULSE);
  assign pwm_mode = (mode_reg == PTMR_MODE_WAVE) && !sp_mode;
  assign cap_mode = (mode_reg == PTMR_MODE_CAP);
  assign cmp_mode = (mode_reg == PTMR_MODE_CMP);

  assign pins = {external_timer_clock_pin, timer_io_pin_second_in, timer_io_pin_first_in};

  ptmr_edge #(.W(3)) u_edge (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .din(pins),
    .rise(rise_v),
    .fall(fall_v)
  );

  assign cap_rise = cap_src_reg ? rise_v[PTMR_SRC_EXT] :
                    (pin_sel_reg ? rise_v[PTMR_SRC_SECOND] : rise_v[PTMR_SRC_FIRST]);
  assign cap_fall = cap_src_reg ? fall_v[PTMR_SRC_EXT] :
                    (pin_sel_reg ? fall_v[PTMR_SRC_SECOND] : fall_v[PTMR_SRC_FIRST]);

  always_comb begin
    unique case (pin_fn_reg)
      PTMR_FN_RISE: cap_edge = cap_rise;
      PTMR_FN_FALL: cap_edge = cap_fall;
      PTMR_FN_BOTH: cap_edge = cap_rise || cap_fall;
      PTMR_FN_PULSE: cap_edge = 1'b0;
    endcase
  end
  assign cap_evt = cap_mode && cap_edge;
  assign ext_trig = sp_mode && rise_v[PTMR_SRC_EXT];

  // run bit next value; hardware events outrank a software write
  always_comb begin
    run_next = run_reg;
    if (wr_c0) begin
      run_next = reg_wdata[PTMR_C0_RUN];
    end
    if (ext_trig) begin
      run_next = 1'b1;
    end
    if (sp_mode && cnt.a_hit) begin
      run_next = 1'b0;
    end
  end
  // rising run bit is the trigger
  assign start = run_next && !run_reg;

  // counter controls
  // clear strobe at start; period and A-clear matches also zero the count in the counter
  assign cnt.clear = start;
  assign cnt.en = run_reg;
  assign cnt.p_clr_en = cap_mode || pwm_mode || ((cmp_mode || mode_reg == PTMR_MODE_TIMER) && !cclr_reg);
  assign cnt.a_clr_en = (cmp_mode || mode_reg == PTMR_MODE_TIMER) && cclr_reg;
  assign cnt.cmp_a = cmp_a_reg;
  assign cnt.cmp_p = cmp_p_reg;

  ptmr_counter #(.W(CNT_W)) u_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .bus(cnt)
  );

  // run bit and its effects
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_reg <= PTMR_RST_BIT;
    end else if (ce) begin
      run_reg <= run_next;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_src_reg <= PTMR_RST_BIT;
      pin_sel_reg <= PTMR_RST_BIT;
      mode_reg <= PTMR_MODE_CMP;
      pin_fn_reg <= PTMR_RST_FN;
      init_lvl_reg <= PTMR_RST_BIT;
      pol_reg <= PTMR_RST_BIT;
      cclr_reg <= PTMR_RST_BIT;
      cmp_p_reg <= PTMR_RST_CMP;
    end else begin
      if (wr_c0) begin
        cap_src_reg <= reg_wdata[PTMR_C0_CAPSRC];
        pin_sel_reg <= reg_wdata[PTMR_C0_PINSEL];
      end
      if (wr_c1) begin
        mode_reg <= ptmr_mode_e'(reg_wdata[PTMR_C1_MODE_HI:PTMR_C1_MODE_LO]);
        pin_fn_reg <= reg_wdata[PTMR_C1_FN_HI:PTMR_C1_FN_LO];
        init_lvl_reg <= reg_wdata[PTMR_C1_INIT];
        pol_reg <= reg_wdata[PTMR_C1_POL];
        cclr_reg <= reg_wdata[PTMR_C1_CCLR];
      end
      if (wr_p) begin
        cmp_p_reg <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // compare A; a capture beats a software write in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_a_reg <= PTMR_RST_CMP;
    end else if (ce) begin
      if (cap_evt) begin
        cmp_a_reg <= cnt.count;
      end else if (wr_a) begin
        cmp_a_reg <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // request flags, write one clears, a same-cycle set wins
  // A flag on match or capture
  assign set_a = cap_evt || (!cap_mode && cnt.a_hit);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_a_reg <= PTMR_RST_BIT;
      flag_p_reg <= PTMR_RST_BIT;
    end else if (ce) begin
      flag_a_reg <= (flag_a_reg && !(wr_fl && reg_wdata[PTMR_FL_A])) || set_a;
      flag_p_reg <= (flag_p_reg && !(wr_fl && reg_wdata[PTMR_FL_P])) || cnt.p_hit;
    end
  end

  // compare output level, restarted by the run bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_lvl_reg <= PTMR_RST_BIT;
    end else if (ce) begin
      if (start) begin
        cmp_lvl_reg <= init_lvl_reg;
      end else if (cmp_mode && cnt.a_hit) begin
        unique case (pin_fn_reg)
          2'b00: cmp_lvl_reg <= cmp_lvl_reg;
          2'b01: cmp_lvl_reg <= 1'b0;
          2'b10: cmp_lvl_reg <= 1'b1;
          2'b11: cmp_lvl_reg <= !cmp_lvl_reg;
        endcase
      end
    end
  end

  // pin level; pulse follows the next run value so it starts with the count
  always_comb begin
    lvl = cmp_lvl_reg;
    if (sp_mode) begin
      lvl = run_next ? init_lvl_reg : !init_lvl_reg;
    end else if (pwm_mode) begin
      unique case (pin_fn_reg)
        PTMR_FN_FORCE_LO: lvl = 1'b0;
        PTMR_FN_FORCE_HI: lvl = 1'b1;
        default: lvl = (cnt.count < cmp_a_reg) ? init_lvl_reg : !init_lvl_reg;
      endcase
    end
  end

  // pin drive; capture and timer modes leave the pins undriven
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out_reg <= PTMR_RST_BIT;
      pin_oe_n_reg <= 1'b1;
    end else if (ce) begin
      pin_out_reg <= (cap_mode || mode_reg == PTMR_MODE_TIMER) ? 1'b0 : (lvl ^ pol_reg);
      pin_oe_n_reg <= cap_mode || (mode_reg == PTMR_MODE_TIMER);
    end
  end

  // register read, data the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= PTMR_RST_RDATA;
    end else if (ce && reg_re) begin
      rdata_reg <= PTMR_RST_RDATA;
      unique case (reg_addr)
        PTMR_OFF_TIMER_CONTROL_ZERO: begin
          rdata_reg[PTMR_C0_RUN] <= run_reg;
          rdata_reg[PTMR_C0_CAPSRC] <= cap_src_reg;
          rdata_reg[PTMR_C0_PINSEL] <= pin_sel_reg;
        end
        PTMR_OFF_TIMER_CONTROL_ONE: begin
          rdata_reg[PTMR_C1_MODE_HI:PTMR_C1_MODE_LO] <= mode_reg;
          rdata_reg[PTMR_C1_FN_HI:PTMR_C1_FN_LO] <= pin_fn_reg;
          rdata_reg[PTMR_C1_INIT] <= init_lvl_reg;
          rdata_reg[PTMR_C1_POL] <= pol_reg;
          rdata_reg[PTMR_C1_CCLR] <= cclr_reg;
        end
        PTMR_OFF_COUNT: rdata_reg[CNT_W-1:0] <= cnt.count;
        PTMR_OFF_COMPARE_A: rdata_reg[CNT_W-1:0] <= cmp_a_reg;
        PTMR_OFF_PERIOD_COMPARE: rdata_reg[CNT_W-1:0] <= cmp_p_reg;
        PTMR_OFF_FLAGS: begin
          rdata_reg[PTMR_FL_A] <= flag_a_reg;
          rdata_reg[PTMR_FL_P] <= flag_p_reg;
        end
        default: rdata_reg <= PTMR_RST_RDATA;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign timer_io_pin_first_out = pin_out_reg;
  assign timer_io_pin_first_oe_n = pin_oe_n_reg;
  assign timer_io_pin_second_out = pin_out_reg;
  assign timer_io_pin_second_oe_n = pin_oe_n_reg;
  assign a_match_flag = flag_a_reg;
  assign p_match_flag = flag_p_reg;

  // checks on the documented behaviour
  AST_EXT_SETS_RUN: assert property (@(posedge core_clk) disable iff (rst)
    ce && ext_trig && !cnt.a_hit |=> run_reg)
    else $error("external edge did not set run bit");

  AST_START_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    ce && start |=> run_reg && (cnt.count == 10'h000))
    else $error("counter not zero at start");

  AST_SP_A_STOPS: assert property (@(posedge core_clk) disable iff (rst)
    ce && sp_mode && cnt.a_hit |=> !run_reg && (cnt.count == $past(cmp_a_reg)))
    else $error("A match did not end pulse");

  AST_SP_A_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    ce && sp_mode && cnt.a_hit |=> flag_a_reg)
    else $error("A flag missing in pulse mode");

  AST_SP_PIN: assert property (@(posedge core_clk) disable iff (rst)
    ce && sp_mode && !reg_we |=> pin_out_reg == ((run_reg ? init_lvl_reg : !init_lvl_reg) ^ pol_reg))
    else $error("pulse pin does not follow run bit");

  AST_CAP_LATCH: assert property (@(posedge core_clk) disable iff (rst)
    ce && cap_evt |=> (cmp_a_reg == $past(cnt.count)) && flag_a_reg)
    else $error("capture did not latch count");

  AST_CAP_OFF: assert property (@(posedge core_clk) disable iff (rst)
    ce && cap_mode && (pin_fn_reg == 2'b11) && !reg_we |=> $stable(cmp_a_reg))
    else $error("capture happened with function 11");

  AST_CAP_PERIOD: assert property (@(posedge core_clk) disable iff (rst)
    ce && cap_mode && run_reg && !start && ((cnt.count + 10'h001) == cmp_p_reg) |=>
    (cnt.count == 10'h000) && flag_p_reg)
    else $error("period match did not clear counter");

  AST_CAP_FREE: assert property (@(posedge core_clk) disable iff (rst)
    ce && cap_mode && run_reg && !start && !cnt.p_hit |=> cnt.count == ($past(cnt.count) + 10'h001))
    else $error("capture counter did not advance");

  AST_STOP_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    ce && !run_reg && !start |=> $stable(cnt.count))
    else $error("stopped counter moved");

  COV_EXT_PULSE: cover property (@(posedge core_clk) disable iff (rst)
    ext_trig ##[1:1000] (sp_mode && cnt.a_hit));
  COV_CAPTURE: cover property (@(posedge core_clk) disable iff (rst) ce && cap_evt);
  COV_PWRAP: cover property (@(posedge core_clk) disable iff (rst) ce && cap_mode && cnt.p_hit);
endmodule : ptmr_top

// file: test/periodic_timer_pulse_capture_tb.sv
// periodic_timer_pulse_capture_tb: self-checking bench for single pulse, capture and pwm.
// assumes ptmr_top with a plain register port and the pin model as the edge source.
module periodic_timer_pulse_capture_tb
  import ptmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, ce, reg_we, reg_re, rd_pend;
  logic [2:0] reg_addr, req_lvl, pin_lvl;
  logic [3:0] lag;
  logic [15:0] reg_wdata, reg_rdata, hi_base;
  logic [15:0] hi_cnt = 16'h0;
  logic first_out, first_oe_n, second_out, second_oe_n, first_w, second_w, a_flag, p_flag;
  logic [9:0] pw;
  logic [15:0] exp_q[$];
  int n_fail, checks_done;

  // io pins resolve to the timer drive while enabled, else to the far side
  assign first_w = first_oe_n ? pin_lvl[0] : first_out;
  assign second_w = second_oe_n ? pin_lvl[1] : second_out;

  ptmr_top u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .external_timer_clock_pin(pin_lvl[2]),
    .timer_io_pin_first_in(first_w), .timer_io_pin_first_out(first_out), .timer_io_pin_first_oe_n(first_oe_n),
    .timer_io_pin_second_in(second_w), .timer_io_pin_second_out(second_out),
    .timer_io_pin_second_oe_n(second_oe_n), .a_match_flag(a_flag), .p_match_flag(p_flag));

  ptmr_pin_model u_pins (.core_clk(core_clk), .req_lvl(req_lvl), .lag(lag), .pin_lvl(pin_lvl));

  always #5 core_clk = ~core_clk;

  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk1(input logic got, input logic exp);
    cmp({15'h0, got}, {15'h0, exp});
  endtask : chk1

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask : wr

  // the expected word waits in the queue until the read data appear
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_re <= 1'b0;
  endtask : rd

  // read data appear in the cycle after the strobe and are checked there
  always @(posedge core_clk) rd_pend <= reg_re;
  always @(negedge core_clk) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0) cmp(reg_rdata, exp_q.pop_front());
  end

  // width of the pulse in cycles, counted on the driven pin
  always @(posedge core_clk) begin
    if (first_out === 1'b1 && first_oe_n === 1'b0) hi_cnt <= hi_cnt + 16'h1;
  end

  // sampled at the falling edge, so a flag cleared at the last rising edge is seen cleared
  task automatic wait_a();
    int k;
    @(negedge core_clk);
    for (k = 0; k < 300 && a_flag !== 1'b1; k++) @(negedge core_clk);
    if (a_flag !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask : wait_a

  function automatic logic [15:0] c1(logic [1:0] m, logic [1:0] f, logic lvl, logic pol, logic cc);
    return {8'h0, m, f, lvl, pol, 1'b0, cc};
  endfunction : c1

  // one edge on the wrong source first, which must leave compare A alone, then on the chosen one
  task automatic cap_edge(input int s, input logic lvl, input logic hit);
    wr(PTMR_OFF_COMPARE_A, 16'h02aa);
    wr(PTMR_OFF_FLAGS, 16'h0001);
    req_lvl[(s + 1) % 3] <= lvl;
    repeat (4) @(posedge core_clk);
    rd(PTMR_OFF_COMPARE_A, 16'h02aa); // unselected source ignored
    req_lvl[s] <= lvl;
    repeat (4) @(posedge core_clk);
    rd(PTMR_OFF_COMPARE_A, hit ? 16'h0000 : 16'h02aa); // edge kind decides capture
    @(negedge core_clk);
    chk1(a_flag, hit); // flag with capture
  endtask : cap_edge

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 16'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    req_lvl = 3'h0;
    lag = 4'h0;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(32'h1040a1cd));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, unmapped index 6 included
    for (int i = 0; i < 7; i++) rd(3'(i), 16'h0000);
    wr(PTMR_OFF_COMPARE_A, 16'hffff);
    rd(PTMR_OFF_COMPARE_A, 16'h03ff); // ten bits held
    // single pulse, with a short period and counter clear select that must not matter
    pw = 10'(3 + $urandom % 16);
    wr(PTMR_OFF_COMPARE_A, {6'h0, pw});
    wr(PTMR_OFF_PERIOD_COMPARE, 16'h0002);
    wr(PTMR_OFF_TIMER_CONTROL_ONE, c1(2'b10, 2'b11, 1'b1, 1'b0, 1'b1)); // pulse mode, function kept 11
    hi_base = hi_cnt;
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0001);
    @(negedge core_clk);
    chk1(first_out, 1'b1); // leading edge with run
    wait_a(); // flag on A match
    rd(PTMR_OFF_COUNT, {6'h0, pw}); // count stops at A
    rd(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0000); // run cleared by match
    @(negedge core_clk);
    chk1(first_out, 1'b0); // trailing edge
    cmp(hi_cnt - hi_base, {6'h0, pw}); // width set by A
    // slow external edge retriggers; the count must restart from zero
    wr(PTMR_OFF_FLAGS, 16'h0003);
    hi_base = hi_cnt;
    lag <= 4'h3;
    req_lvl <= 3'b100;
    wait_a(); // external edge sets run
    @(negedge core_clk);
    cmp(hi_cnt - hi_base, {6'h0, pw}); // restart from zero
    req_lvl <= 3'b000;
    // software ends a long pulse early
    wr(PTMR_OFF_COMPARE_A, 16'h03ff);
    wr(PTMR_OFF_FLAGS, 16'h0003);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0001);
    repeat (4) @(posedge core_clk);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0000);
    @(negedge core_clk);
    chk1(first_out, 1'b0); // software trailing edge
    chk1(a_flag, 1'b0); // no match, no flag
    // capture: period 1 pins the count at zero, so a capture reads back as zero
    lag <= 4'h0;
    wr(PTMR_OFF_PERIOD_COMPARE, 16'h0001);
    for (int f = 0; f < 4; f++) begin
      for (int s = 0; s < 3; s++) begin
        wr(PTMR_OFF_TIMER_CONTROL_ONE, c1(2'b01, 2'(f), 1'b1, 1'b1, 1'b1)); // capture mode
        wr(PTMR_OFF_TIMER_CONTROL_ZERO, {13'h0, s == 1, s == 2, 1'b1}); // source select
        cap_edge(s, 1'b1, f == 0 || f == 2); // rising
        cap_edge(s, 1'b0, f == 1 || f == 2); // falling
      end
    end
    // period match in capture; an A clear select must not cut the count short
    wr(PTMR_OFF_TIMER_CONTROL_ONE, c1(2'b01, 2'b00, 1'b0, 1'b0, 1'b1));
    wr(PTMR_OFF_COMPARE_A, 16'h0002);
    wr(PTMR_OFF_PERIOD_COMPARE, 16'h0004);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0000);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0001); // software start
    wr(PTMR_OFF_FLAGS, 16'h0003);
    repeat (12) @(negedge core_clk);
    chk1(p_flag, 1'b1); // period match flag
    chk1(a_flag, 1'b0); // no A event without an edge
    // zero period runs the whole ten-bit range before wrapping
    wr(PTMR_OFF_PERIOD_COMPARE, 16'h0000);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0000);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0001);
    wr(PTMR_OFF_FLAGS, 16'h0003);
    repeat (1000) @(negedge core_clk);
    chk1(p_flag, 1'b0); // no wrap before 1024
    repeat (60) @(negedge core_clk);
    chk1(p_flag, 1'b1); // wrap at full count
    // pwm with the pin forced keeps counting; clear select ignored
    wr(PTMR_OFF_TIMER_CONTROL_ONE, c1(2'b10, 2'b00, 1'b1, 1'b0, 1'b1));
    wr(PTMR_OFF_PERIOD_COMPARE, 16'h0004);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0000);
    wr(PTMR_OFF_TIMER_CONTROL_ZERO, 16'h0001);
    wr(PTMR_OFF_FLAGS, 16'h0003);
    repeat (12) @(negedge core_clk);
    chk1(p_flag, 1'b1); // counting goes on
    chk1(first_out, 1'b0); // forced low
    wr(PTMR_OFF_TIMER_CONTROL_ONE, c1(2'b10, 2'b01, 1'b1, 1'b0, 1'b1));
    repeat (3) @(negedge core_clk);
    chk1(first_out, 1'b1); // forced high
    // live pwm: with A at 2 and period 4 the pin is high for two of every four counts
    wr(PTMR_OFF_TIMER_CONTROL_ONE, c1(2'b10, 2'b10, 1'b1, 1'b0, 1'b1));
    repeat (2) @(negedge core_clk);
    hi_base = hi_cnt;
    repeat (8) @(negedge core_clk);
    cmp(hi_cnt - hi_base, 16'h0004); // duty from A, period from P
    // a write strobe while the clock enable is low must leave compare A alone
    ce <= 1'b0;
    wr(PTMR_OFF_COMPARE_A, 16'h0155);
    ce <= 1'b1;
    rd(PTMR_OFF_COMPARE_A, 16'h0002); // A held while frozen
    repeat (3) @(posedge core_clk);
    complete_run();
  end
endmodule : periodic_timer_pulse_capture_tb

// file: test/ptmr_pin_model.sv
// ptmr_pin_model: far side of the timer pins, the sources of trigger and capture edges.
// assumes the bench asks for pin levels; the pins follow after a chosen lag.
module ptmr_pin_model (
  input wire logic core_clk,      // timer clock
  input wire logic [2:0] req_lvl, // wanted levels: ext, second, first
  input wire logic [3:0] lag,     // cycles a source waits before moving
  output logic [2:0] pin_lvl      // pin levels seen by the timer
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins start low, the idle level the edge detector assumes after reset
  logic [2:0] lvl_reg = 3'h0;
  logic [3:0] wait_reg = 4'h0;

  assign pin_lvl = lvl_reg;

  // a slow source holds its old level for lag cycles, so late edges get exercised too
  always @(posedge core_clk) begin
    if (lvl_reg == req_lvl) wait_reg <= lag;
    else if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
    else lvl_reg <= req_lvl;
  end
endmodule : ptmr_pin_model
